// File: design/lvt_src.sv
/*
  Video source end: drains eight-pixel words from a FIFO onto the
  eight link ports with line and frame blanking, makes the link clock.
  Assumes the user pushes words in pixel order and the panel end
  answers with the polarity index.
*/
// What this block does
// - Channels are unsigned eight-bit gray levels.
// - Green field runs bit 7 down to 0.
// - Blue field runs bit 7 down to 0.
// - Every frame carries ACTIVE_LINES active lines, 1440 by default.
// - Vertical blanking is 12 to 6752 lines.
// - Frame period is ACTIVE_LINES plus 12 to 6752 lines; 1452 to 8192 by default.
// - Frame rate should be 30 to 145 Hz; the scaled 2.5 MHz link clock gives about 4.7 Hz.
// - Line period is 359 to 1023 clocks.
// - Active line is exactly 320 pixel clocks.
// - Horizontal blanking is 39 to 703 clocks.
// - Pixel clock should be 25 to 90 MHz; this model runs it at 2.5 MHz.
// - Rate times line times frame below maximum.
// - Prefer frame rates of 119 to 145 Hz; the scaled model runs at about 4.7 Hz.
// - Spread spectrum deviates at most three percent.
// - Spread modulation at most 200 kHz.
// - Polarity index flips per one or two frames.
// - Stereo pin floats low via weak pulldown.
// - Lanes high impedance while supply off.
// - Lanes high impedance during power-down intervals.
// - Make the first power-down interval zero.
// - Dimming pulses follow the frame rate.
// - Ports interleave pixels modulo four per half.
`timescale 1ns/1ps
`include "lvt_cfg.svh"
module lvt_src #(
  parameter int LINE_BLANK = `LVT_H_BLK_TYP,
  parameter int FRAME_BLANK = `LVT_V_BLK_TYP,
  parameter int ACTIVE_LINES = `LVT_V_ACT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pixel words from the user
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [191:0] in_data,
  // Panel control
  input wire logic panel_power_on,
  input wire logic stereo_on,
  // Status
  output logic frame_sync_q,
  output logic underrun_q,
  output logic polarity_q,
  // Link
  lvt_if.src lnk
);

  // ******************************************************************
  // Timing limits
  // ******************************************************************
  function automatic int clamp(int v, int lo, int hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Blanking is held inside its legal span whatever is asked.
  localparam int HBLK = clamp(LINE_BLANK, `LVT_H_BLK_MIN,
                              `LVT_H_BLK_MAX);
  // Vertical blanking likewise.
  localparam int VBLK = clamp(FRAME_BLANK, `LVT_V_BLK_MIN,
                              `LVT_V_BLK_MAX);
  // Line period is active plus blanking.
  localparam logic [9:0] H_LAST = 10'(`LVT_H_ACT + HBLK - 1);
  // Frame period is active lines plus blanking.
  localparam logic [12:0] V_LAST = 13'(ACTIVE_LINES + VBLK - 1);
  localparam logic [9:0] H_ACT = 10'(`LVT_H_ACT);
  localparam logic [12:0] V_ACT = 13'(ACTIVE_LINES);
  localparam logic [2:0] DIV_LAST = 3'(`LVT_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(`LVT_DIV / 2);

  // ******************************************************************
  // Power state
  // ******************************************************************
  lvt_pkg::lvt_src_st_t st_q;
  lvt_pkg::lvt_src_st_t st_d;

  always_comb begin
    st_d = st_q;
    case (st_q)
      lvt_pkg::LVT_ST_OFF: begin
        if (panel_power_on) begin
          st_d = lvt_pkg::LVT_ST_RUN;
        end
      end
      lvt_pkg::LVT_ST_RUN: begin
        // Dropping at once keeps the first power-down gap at zero.
        if (!panel_power_on) begin
          st_d = lvt_pkg::LVT_ST_OFF;
        end
      end
      default: begin
        st_d = lvt_pkg::LVT_ST_OFF;
      end
    endcase
  end

  wire run = st_q == lvt_pkg::LVT_ST_RUN;

  // ******************************************************************
  // Link clock divider
  // ******************************************************************
  // A fixed divider has no spread, well inside the deviation
  // and modulation limits.
  // The rate here is a scaled model; a real link clock must sit in
  // its legal band, and with it the product of rate, line and frame
  // periods stays below the maximum.
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic clk_q;

  assign div_d = (div_q == DIV_LAST || !run) ? 3'h0 : div_q + 3'h1;
  wire tick = run && div_q == DIV_LAST;

  // ******************************************************************
  // Raster position
  // ******************************************************************
  logic [9:0] h_q;
  logic [12:0] v_q;
  logic [9:0] h_d;
  logic [12:0] v_d;

  wire h_end = h_q == H_LAST;
  wire v_end = v_q == V_LAST;
  assign h_d = h_end ? 10'h000 : h_q + 10'h001;
  assign v_d = !h_end ? v_q : (v_end ? 13'h0000 : v_q + 13'h0001);

  // Active for exactly 320 clocks of each of the active lines,
  // and so a frame rate set only by the clock and periods.
  // Chosen periods give the frame rate band and, at the typical
  // clock, the preferred one.
  wire active = h_q < H_ACT && v_q < V_ACT;

  // ******************************************************************
  // Pixel FIFO
  // ******************************************************************
  logic f_valid;
  logic [191:0] f_data;
  wire pop = tick & active & f_valid;

  lvt_fifo #(
    .W(`LVT_WORD_W),
    .DEPTH(`LVT_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  // ******************************************************************
  // Polarity index from the panel
  // ******************************************************************
  logic [2:0] pol_s_q;

  // ******************************************************************
  // Link and status registers
  // ******************************************************************
  logic [7:0] de_q;
  logic [191:0] dat_q;
  logic oe_q;
  logic st_en_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= lvt_pkg::LVT_ST_OFF;
      div_q <= 3'h0;
      clk_q <= 1'b0;
      oe_q <= 1'b0;
      st_en_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      // Data moves at the low phase; the rising edge is mid-bit.
      clk_q <= run && div_d >= DIV_HALF;
      // Lanes released while the supply is off or going down.
      oe_q <= st_d == lvt_pkg::LVT_ST_RUN;
      st_en_q <= stereo_on;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      h_q <= 10'h000;
      v_q <= 13'h0000;
    end else if (!run) begin
      h_q <= 10'h000;
      v_q <= 13'h0000;
    end else if (tick) begin
      h_q <= h_d;
      v_q <= v_d;
    end
  end

  // Word lane p carries pixel 4k+p+1 of its half: lanes 0 to 3 the
  // left half, lanes 4 to 7 from pixel 1281 on.
  // Each lane is red, then green and blue, bit 7 first.
  // An empty FIFO sends black rather than stalling the raster.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      de_q <= 8'h00;
      dat_q <= 192'h0;
      underrun_q <= 1'b0;
    end else if (!run) begin
      de_q <= 8'h00;
      dat_q <= 192'h0;
    end else if (tick) begin
      de_q <= active ? 8'hff : 8'h00;
      dat_q <= pop ? f_data : 192'h0;
      underrun_q <= underrun_q | (active & ~f_valid);
    end
  end

  // One pulse per frame so backlight dimming can lock to it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_sync_q <= 1'b0;
    end else begin
      frame_sync_q <= tick && h_q == 10'h000 && v_q == 13'h0000;
    end
  end

  // Three stages; a change counts once the last two agree.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pol_s_q <= 3'h0;
      polarity_q <= 1'b0;
    end else begin
      pol_s_q <= {pol_s_q[1:0], lnk.pol_rx};
      if (pol_s_q[1] == pol_s_q[2]) begin
        polarity_q <= pol_s_q[2];
      end
    end
  end

  assign lnk.clk_tx = {8{clk_q}};
  assign lnk.de_tx = de_q;
  assign lnk.dat_tx = dat_q;
  assign lnk.lvds_oe = oe_q;
  assign lnk.stereo_tx = st_en_q;
  assign lnk.stereo_oe = oe_q;

endmodule

// File: design/lvt_cfg.svh
/*
  Timing counts, widths and limits of the eight-port video link.
  Assumes a 20 MHz system clock; included by its bare name.
*/
`ifndef LVT_CFG_SVH
`define LVT_CFG_SVH

// ********************************************************************
// Link shape
// ********************************************************************
`define LVT_PORTS 8
`define LVT_CH_W 8
`define LVT_PIX_W 24
`define LVT_WORD_W 192
`define LVT_HALF_PIX 1280
`define LVT_FIFO_DEPTH 8

// ********************************************************************
// Line and frame timing, in pixel clocks and line periods
// ********************************************************************
`define LVT_H_ACT 320
`define LVT_H_BLK_MIN 39
`define LVT_H_BLK_TYP 40
`define LVT_H_BLK_MAX 703
`define LVT_LINE_MIN 359
`define LVT_LINE_TYP 360
`define LVT_LINE_MAX 1023
`define LVT_V_ACT 1440
`define LVT_V_BLK_MIN 12
`define LVT_V_BLK_TYP 41
`define LVT_V_BLK_MAX 6752
`define LVT_FRAME_MIN 1452
`define LVT_FRAME_TYP 1481
`define LVT_FRAME_MAX 8192

// ********************************************************************
// Rates, spread spectrum and power-down
// ********************************************************************
`define LVT_FV_MIN_HZ 30
`define LVT_FV_TYP_HZ 120
`define LVT_FV_MAX_HZ 145
`define LVT_FV_BEST_MIN_HZ 119
`define LVT_FCLK_MIN_MHZ 25
`define LVT_FCLK_TYP_MHZ 64
`define LVT_FCLK_MAX_MHZ 90
`define LVT_SSC_DEV_PCT 3
`define LVT_SSC_MOD_KHZ 200
`define LVT_T5_MAX_MS 50
`define LVT_T5_REC_MS 0
`define LVT_T6_MAX_MS 150

// ********************************************************************
// Clocks of this implementation
// ********************************************************************
`define LVT_SYS_NS 50
`define LVT_LINK_NS 400
`define LVT_DIV (`LVT_LINK_NS / `LVT_SYS_NS)
`define LVT_DIV_W 3

`endif

// File: design/lvt_pkg.sv
/*
  Types of the video link, used by the source end only.
  Assumes lvt_cfg.svh is compiled alongside.
*/
package lvt_pkg;

  // ******************************************************************
  // Pixel and state types
  // ******************************************************************
  // Unsigned gray levels per channel, bit 7 the most significant.
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } lvt_pixel_t;

  typedef enum logic [1:0] {
    LVT_ST_OFF = 2'b01,
    LVT_ST_RUN = 2'b10
  } lvt_src_st_t;

endpackage

// File: design/lvt_if.sv
/*
  Carrier joining the video source and the panel input.
  Assumes the source end drives the lanes and the panel drives polarity.
*/
`timescale 1ns/1ps
interface lvt_if;

  // ******************************************************************
  // Driven by the source
  // ******************************************************************
  logic [7:0] clk_tx;
  logic [7:0] de_tx;
  logic [191:0] dat_tx;
  logic lvds_oe;
  logic stereo_tx;
  logic stereo_oe;

  // ******************************************************************
  // Levels seen at the panel
  // ******************************************************************
  logic [7:0] clk_w;
  logic [7:0] de_w;
  logic [191:0] dat_w;
  logic stereo_w;
  logic pol_rx;

  // Undriven lanes are read as low.
  assign clk_w = lvds_oe ? clk_tx : 8'h00;
  assign de_w = lvds_oe ? de_tx : 8'h00;
  assign dat_w = lvds_oe ? dat_tx : 192'h0;
  // The weak internal pulldown makes a floating stereo pin low.
  assign stereo_w = stereo_oe ? stereo_tx : 1'b0;

  modport src (
    output clk_tx, de_tx, dat_tx, lvds_oe, stereo_tx, stereo_oe,
    input pol_rx
  );
  modport dev (
    input clk_w, de_w, dat_w, stereo_w,
    output pol_rx
  );

endinterface

// File: design/lvt_fifo.sv
/*
  Word FIFO with valid and ready on both sides, flip-flop storage.
  Assumes DEPTH is a power of two and one clock domain.
*/
`timescale 1ns/1ps
module lvt_fifo #(
  parameter int W = 192,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  logic val_q;

  wire push = in_valid & rdy_q;
  wire pop = val_q & out_ready;

  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = rdy_q;
  assign out_valid = val_q;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      val_q <= 1'b0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_d;
      rdy_q <= cnt_d != (AW+1)'(DEPTH);
      val_q <= cnt_d != '0;
    end
  end

  // Storage has no reset; only written words are ever read.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule

// File: design/lvt_dev.sv
/*
  Panel input end: samples the eight link ports on the system clock,
  finds lines and frames from data enable, drives the polarity index.
  Assumes all ports share one raster and the source keeps the timing.
*/
`timescale 1ns/1ps
`include "lvt_cfg.svh"
module lvt_dev (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  lvt_if.dev lnk,
  // Pixel words to the user
  output logic pix_valid_q,
  output logic [191:0] pix_word_q,
  output logic line_start_q,
  output logic frame_start_q,
  output logic [12:0] line_idx_q,
  // Status
  output logic stereo_q,
  output logic polarity_q
);

  localparam logic [9:0] HBLK_MAX = 10'(`LVT_H_BLK_MAX);

  // ******************************************************************
  // Input synchronisers
  // ******************************************************************
  logic [208:0] s1_q;
  logic [208:0] s2_q;
  logic [208:0] s3_q;
  logic [7:0] lvl_q;
  wire [7:0] c2 = s2_q[207:200];
  wire [7:0] c3 = s3_q[207:200];
  wire [7:0] de3 = s3_q[199:192];
  // Clock edge once two stages agree high after a low level.
  wire [7:0] rise = c2 & c3 & ~lvl_q;
  wire [7:0] lvl_d = (c2 & c3) | (lvl_q & (c2 | c3));

  // ******************************************************************
  // Per-port line and frame tracking
  // ******************************************************************
  logic [7:0] de_p_q;
  logic [7:0] vb_q;
  logic [9:0] blank_q [8];
  logic [12:0] line_q [8];
  logic [1:0] fcnt_q;

  wire sol0 = rise[0] & de3[0] & ~de_p_q[0];
  wire sof0 = sol0 & vb_q[0];
  wire [1:0] fcnt_d = fcnt_q + 2'(sof0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= 8'h00;
    end else begin
      s1_q <= {lnk.stereo_w, lnk.clk_w, lnk.de_w, lnk.dat_w};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // A blanking run longer than any line blanking marks the frame gap;
  // the next rising data enable restarts the counters.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      de_p_q <= 8'h00;
      vb_q <= 8'hff;
      for (int p = 0; p < 8; p++) begin
        blank_q[p] <= 10'h000;
        line_q[p] <= 13'h0000;
      end
    end else begin
      for (int p = 0; p < 8; p++) begin
        if (rise[p]) begin
          de_p_q[p] <= de3[p];
          if (de3[p] && !de_p_q[p]) begin
            blank_q[p] <= 10'h000;
            vb_q[p] <= 1'b0;
            line_q[p] <= vb_q[p] ? 13'h0000 : line_q[p] + 13'h0001;
          end else if (!de3[p] && blank_q[p] != 10'h3ff) begin
            blank_q[p] <= blank_q[p] + 10'h001;
            if (blank_q[p] >= HBLK_MAX) begin
              vb_q[p] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ******************************************************************
  // User outputs and polarity
  // ******************************************************************
  // Words keep the lane order and eight-bit unsigned channels,
  // green and blue each bit 7 first.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_valid_q <= 1'b0;
      pix_word_q <= 192'h0;
      line_start_q <= 1'b0;
      frame_start_q <= 1'b0;
      line_idx_q <= 13'h0000;
      fcnt_q <= 2'h0;
      stereo_q <= 1'b0;
      polarity_q <= 1'b0;
    end else begin
      pix_valid_q <= rise[0] & de3[0];
      if (rise[0] && de3[0]) begin
        pix_word_q <= s3_q[191:0];
      end
      line_start_q <= sol0;
      frame_start_q <= sof0;
      if (sol0) begin
        line_idx_q <= vb_q[0] ? 13'h0000 : line_q[0] + 13'h0001;
      end
      fcnt_q <= fcnt_d;
      if (s2_q[208] == s3_q[208]) begin
        stereo_q <= s3_q[208];
      end
      // One-frame pattern normally, two-frame in stereo.
      polarity_q <= stereo_q ? fcnt_d[1] : fcnt_d[0];
    end
  end

  assign lnk.pol_rx = polarity_q;

endmodule

// File: dv/lvt_link_props.sv
/*
  Concurrent checks on the link between the video source and the panel.
  Assumes the bench hands over the carrier's signals and the source's
  timing parameters.
*/
`timescale 1ns/1ps
module lvt_link_props #(
  parameter int ACTIVE_LINES = 1440,
  parameter int LINE_BLANK = 40,
  parameter int FRAME_BLANK = 41
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Lanes as driven by the source
  input wire logic [7:0] clk_tx,
  input wire logic [7:0] de_tx,
  input wire logic [191:0] dat_tx,
  input wire logic lvds_oe,
  // Control pins
  input wire logic stereo_w,
  input wire logic pol_rx
);
  // ******************************************************************
  // Blank and frame bookkeeping
  // ******************************************************************
  // A blank run longer than the longest line blank can only be a frame gap.
  localparam int GAP = 703 * 8;
  localparam int LBLK = LINE_BLANK * 8;
  localparam int FBLK = (FRAME_BLANK * (320 + LINE_BLANK) + LINE_BLANK) * 8;
  localparam int FPER =
    (ACTIVE_LINES + FRAME_BLANK) * (320 + LINE_BLANK) * 8 - 1;
  logic de_q;
  logic [15:0] act_q;
  logic [15:0] blk_q;
  logic [15:0] per_q;
  logic [12:0] ln_q;
  logic [7:0] fc_q;
  wire de_rise = de_tx[0] && !de_q;
  wire fstart = de_rise && blk_q >= GAP;
  // The all-ones count means no blank has been measured since power-on.
  wire seen = blk_q != 16'hffff;
  wire [15:0] blk_inc = seen ? blk_q + 16'h1 : blk_q;
  wire [15:0] blk_d = !lvds_oe ? 16'hffff : de_tx[0] ? 16'h0 : blk_inc;
  wire [15:0] act_d = de_tx[0] ? act_q + 16'h1 : 16'h0;
  wire [12:0] ln_d = !de_rise ? ln_q : fstart ? 13'h1 : ln_q + 13'h1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {de_q, act_q, blk_q, per_q, ln_q, fc_q} <= {1'b0, 16'h0, 16'hffff,
        16'h0, 13'h0, 8'h0};
    end else begin
      {de_q, act_q, blk_q, ln_q} <= {de_tx[0], act_d, blk_d, ln_d};
      per_q <= fstart ? 16'h0 : per_q + 16'h1;
      fc_q <= fstart ? fc_q + 8'h1 : fc_q;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_lane_match: assert property (lvds_oe |->
    (clk_tx == 8'h00 || clk_tx == 8'hff) &&
    (de_tx == 8'h00 || de_tx == 8'hff))
    else $error("ports disagree on clock or enable");
  chk_data_hold: assert property (clk_tx[0] |->
    $stable(dat_tx) && $stable(de_tx))
    else $error("lane data moved while the link clock was high");
  chk_clock_period: assert property (
    $rose(clk_tx[0]) ##1 lvds_oe [*8] |-> $rose(clk_tx[0]))
    else $error("link clock period is not eight system clocks");
  chk_active_len: assert property ($fell(de_tx[0]) && lvds_oe |->
    act_q == 16'(320 * 8))
    else $error("active line length wrong");
  chk_line_blank: assert property (de_rise && blk_q < GAP |->
    blk_q == 16'(LBLK))
    else $error("line blank length wrong");
  chk_frame_blank: assert property (fstart && seen |->
    blk_q == 16'(FBLK))
    else $error("frame blank length wrong");
  chk_frame_lines: assert property (fstart && seen |->
    ln_q == 13'(ACTIVE_LINES))
    else $error("active line count per frame wrong");
  chk_frame_period: assert property (fstart && seen |->
    per_q == 16'(FPER))
    else $error("frame period wrong");
  chk_pol_value: assert property (fstart |-> ##16
    pol_rx == (stereo_w ? fc_q[1] : fc_q[0]))
    else $error("polarity index does not follow the frame count");
endmodule

// File: dv/tb.sv
/*
  Self-checking bench: the source end drives the panel end over the
  carrier; words, line marks, polarity and release are judged.
  Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ps
module tb;
  // ******************************************************************
  // Stimulus and instances
  // ******************************************************************
  // Two active lines keep a frame near 40k cycles; blanks at minimum.
  localparam int ACT = 2;
  localparam int NWORDS = 640;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  logic [191:0] in_data = 192'h0;
  logic panel_power_on = 1'b0;
  logic stereo_on = 1'b0;
  logic in_ready, underrun_q, src_pol, pix_valid_q, line_start_q;
  logic frame_start_q, stereo_q, polarity_q, clk_p, frame_sync_q;
  logic [191:0] pix_word_q;
  logic [12:0] line_idx_q;
  int num_errors = 0;
  int num_checks = 0;
  int rx_n = 0;
  int wire_n = 0;
  int ln_n = 0;
  int fs_n = 0;

  always #25 clk_sys = ~clk_sys;

  lvt_if lnk ();
  lvt_src #(.LINE_BLANK(39), .FRAME_BLANK(12), .ACTIVE_LINES(ACT)) u_lvt_src (
    .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .panel_power_on(panel_power_on),
    .stereo_on(stereo_on), .frame_sync_q(frame_sync_q),
    .underrun_q(underrun_q),
    .polarity_q(src_pol), .lnk(lnk));
  lvt_dev u_lvt_dev (
    .clk_sys(clk_sys), .rst(rst), .lnk(lnk), .pix_valid_q(pix_valid_q),
    .pix_word_q(pix_word_q), .line_start_q(line_start_q),
    .frame_start_q(frame_start_q), .line_idx_q(line_idx_q),
    .stereo_q(stereo_q), .polarity_q(polarity_q));
  lvt_link_props #(.ACTIVE_LINES(ACT), .LINE_BLANK(39), .FRAME_BLANK(12))
    u_lvt_link_props (
    .clk_sys(clk_sys), .rst(rst), .clk_tx(lnk.clk_tx), .de_tx(lnk.de_tx),
    .dat_tx(lnk.dat_tx), .lvds_oe(lnk.lvds_oe), .stereo_w(lnk.stereo_w),
    .pol_rx(lnk.pol_rx));

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Word 0 is white; words past the fed frame are black (underrun).
  function automatic logic [191:0] exp_word(input int n);
    logic [191:0] w;
    w = {192{n == 0}};
    for (int p = 0; p < 8; p++) begin
      if (n > 0 && n < NWORDS) w[24*p +: 24] = {8'(n), 8'(p), 8'(~(n >> 3))};
    end
    return w;
  endfunction

  task automatic check_word(input string what, input logic [191:0] exp,
                            input logic [191:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_idx(input string what, input logic [12:0] exp,
                           input logic [12:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp,
                            input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Words are held until ready was seen, so a full FIFO loses nothing.
  task automatic feed(input int n0, input int n1);
    int k;
    k = n0;
    while (k < n1) begin
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_data = exp_word(k);
      if (in_ready === 1'b1) k++;
    end
    @(negedge clk_sys);
    in_valid = 1'b0;
  endtask

  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (fs_n < n && t < 50000) begin
      @(negedge clk_sys);
      t++;
    end
    check_flag("frame arrived", 1'b1, fs_n >= n);
  endtask

  // Both ends are read once the three-stage return sync has settled.
  task automatic check_pol(input logic exp);
    repeat (16) @(negedge clk_sys);
    check_flag("panel polarity", exp, polarity_q);
    check_flag("source polarity", exp, src_pol);
  endtask

  // ******************************************************************
  // Monitor of the wire and of the panel's outputs
  // ******************************************************************
  always @(negedge clk_sys) begin
    if (lnk.clk_w[0] === 1'b1 && clk_p === 1'b0 && lnk.de_w[0] === 1'b1) begin
      check_word("lane data", exp_word(wire_n), lnk.dat_w);
      wire_n++;
    end
    clk_p = lnk.clk_w[0];
    if (frame_sync_q === 1'b1)
      check_flag("frame sync", wire_n % NWORDS == 0, lnk.de_w[0]);
    if (pix_valid_q === 1'b1) begin
      check_word("received word", exp_word(rx_n), pix_word_q);
      rx_n++;
    end
    if (line_start_q === 1'b1) begin
      check_idx("line index", 13'(ln_n % ACT), line_idx_q);
      check_flag("frame start", ln_n % ACT == 0, frame_start_q);
      ln_n++;
    end
    if (frame_start_q === 1'b1) fs_n++;
  end

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic fill_until_refused();
    feed(0, 8);
    repeat (2) @(negedge clk_sys);
    check_flag("ready when full", 1'b0, in_ready);
  endtask

  // One fed frame, then a starved one that must go out black.
  task automatic stream_frames();
    @(negedge clk_sys);
    panel_power_on = 1'b1;
    fork
      feed(8, NWORDS);
      wait_frames(1);
    join
    check_pol(1'b1);
    wait_frames(2);
    check_pol(1'b0);
    check_flag("underrun seen", 1'b1, underrun_q);
  endtask

  task automatic stereo_frames();
    @(negedge clk_sys);
    stereo_on = 1'b1;
    check_pol(1'b1);
    check_flag("stereo seen", 1'b1, stereo_q);
    wait_frames(3);
    check_pol(1'b1);
  endtask

  task automatic power_down();
    @(negedge clk_sys);
    panel_power_on = 1'b0;
    repeat (2) @(negedge clk_sys);
    check_flag("lanes released", 1'b0, lnk.lvds_oe);
    check_flag("enable idle", 1'b0, lnk.de_w[0]);
    repeat (6) @(negedge clk_sys);
    check_flag("floating stereo", 1'b0, stereo_q);
  endtask

  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    fill_until_refused();
    stream_frames();
    stereo_frames();
    power_down();
    complete_run();
  end

  initial begin
    repeat (95000) @(posedge clk_sys);
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    complete_run();
  end
endmodule
